// ==== simplex_fifo_map.vh ====
// constants shared by the single-channel fifo design
// assumes inclusion by bare name from design files only
`ifndef SIMPLEX_FIFO_MAP_VH
`define SIMPLEX_FIFO_MAP_VH

// word and storage geometry
`define DATA_W          32
`define DEPTH           16
`define ADDR_W          4
`define PTR_W           5
`define DEPTH_PTR       5'h10

// channel reset stretch after system reset release, in clocks
`define RST_HOLD        5'h11

// register byte offsets
`define OFF_CTRL        8'h00
`define OFF_STATUS      8'h04
`define OFF_MASK        8'h08
`define OFF_LEVEL       8'h0C

// control fields
`define CTRL_FLUSH      0

// status and mask fields
`define EV_W            5
`define EV_NONEMPTY     0
`define EV_FULL         1
`define EV_TAG          2
`define EV_OVERFLOW     3
`define EV_UNDERFLOW    4

// level register fields
`define LV_PRESENT      0
`define LV_FULL         1
`define LV_TAG          2
`define LV_CHAN_RST     3
`define LV_CNT_LSB      8
`define LV_CNT_MSB      12

// reset values
`define MASK_RST        5'h00
`define STATUS_RST      5'h00

`endif

// ==== ptr_sync.v ====
// gray-coded pointer crossing: binary in, two-stage gray capture, binary out
// assumes the pointer changes by at most one step per clock
`timescale 1ns/1ps

`include "simplex_fifo_map.vh"

module ptr_sync (
  input  wire                mclk_i,
  input  wire                rst_i,
  input  wire                clr_i,
  input  wire [`PTR_W-1:0]   bin_i,
  output wire [`PTR_W-1:0]   bin_o
);

  reg  [`PTR_W-1:0] gray_reg;
  reg  [`PTR_W-1:0] meta_reg;
  reg  [`PTR_W-1:0] sync_reg;
  wire [`PTR_W-1:0] gray_next;

  assign gray_next = bin_i ^ (bin_i >> 1);

  always @(posedge mclk_i or posedge rst_i) begin
    if (rst_i) begin
      gray_reg <= {`PTR_W{1'b0}};
      meta_reg <= {`PTR_W{1'b0}};
      sync_reg <= {`PTR_W{1'b0}};
    end else if (clr_i) begin
      gray_reg <= {`PTR_W{1'b0}};
      meta_reg <= {`PTR_W{1'b0}};
      sync_reg <= {`PTR_W{1'b0}};
    end else begin
      gray_reg <= gray_next;
      meta_reg <= gray_reg;
      sync_reg <= meta_reg;
    end
  end

  // gray back to binary
  genvar g;
  generate
    for (g = 0; g < `PTR_W; g = g + 1) begin : g2b
      assign bin_o[g] = ^sync_reg[`PTR_W-1:g];
    end
  endgenerate

endmodule // ptr_sync

// ==== simplex_fifo_channel.v ====
// one-way fifo channel with fall-through head, level flags and apb status
// assumes producer and consumer logic run on mclk_i; rst_i may come from a pin
//
// The APB interface to the registers and the address map were decided locally.
`timescale 1ns/1ps

`include "simplex_fifo_map.vh"

// Summary of operation
// - without the dual-clock option, distributed style shows a pushed word at the head right after its edge.
// - block-ram style shows a write into an empty fifo one cycle later, or four cycles later with the dual-clock option.
// - after a push the word-present flag rises.
// - a pop from a full fifo drops the full flag.
// - without the dual-clock option, pop with the filling push in one cycle keeps full low.
// - pushes may come on consecutive cycles while full stays low.
// - while word-present is high the oldest word and tag sit at the head.
// - on the pop edge the head advances and present updates; full updates on it too, or three clocks later with the dual-clock option.
// - nonempty, full and tag-seen are level outputs for an interrupt controller.
// - tag-seen is high while the head tag is high and data is held.
// - channel reset output stays high 17 clocks after system reset release.
// - with tag propagation off the head tag output is zero.
// - dual-clock option passes pointers through the gray crossing, still on mclk_i; otherwise pointers are compared directly.
module simplex_fifo_channel #(
  parameter block_ram_style_param = 0,
  parameter dual_clock_param      = 0,
  parameter use_tag_param         = 1
) (
  input  wire                mclk_i,
  input  wire                rst_i,
  output wire                chan_rst_o,
  // producer side
  input  wire                push_i,
  input  wire [`DATA_W-1:0]  push_data_i,
  input  wire                push_tag_i,
  output wire                full_o,
  // consumer side
  output wire [`DATA_W-1:0]  head_data_o,
  output wire                head_tag_o,
  output wire                present_o,
  input  wire                pop_i,
  // level indications
  output wire                nonempty_irq_o,
  output wire                full_irq_o,
  output wire                tag_irq_o,
  // apb slave
  input  wire                psel_i,
  input  wire                penable_i,
  input  wire                pwrite_i,
  input  wire [7:0]          paddr_i,
  input  wire [31:0]         pwdata_i,
  output wire [31:0]         prdata_o,
  output wire                pready_o,
  output wire                pslverr_o,
  output wire                irq_o
);

  // ---------------- channel reset stretch ----------------

  reg  [4:0]          hold_cnt_reg;
  reg                 chan_rst_reg;
  wire                clr;
  reg                 flush_reg;

  always @(posedge mclk_i or posedge rst_i) begin
    if (rst_i) begin
      hold_cnt_reg <= `RST_HOLD;
      chan_rst_reg <= 1'b1;
    end else begin
      if (hold_cnt_reg != 5'h00) begin
        hold_cnt_reg <= hold_cnt_reg - 5'h01;
      end
      chan_rst_reg <= (hold_cnt_reg > 5'h01);
    end
  end

  assign chan_rst_o = chan_rst_reg;
  assign clr        = chan_rst_reg | flush_reg;

  // ---------------- pointers and flags ----------------

  reg  [`PTR_W-1:0]   wr_ptr_reg;
  reg  [`PTR_W-1:0]   rd_ptr_reg;
  reg  [`PTR_W-1:0]   wr_dly_reg;
  wire [`PTR_W-1:0]   wr_seen;
  wire [`PTR_W-1:0]   wr_sync;
  wire [`PTR_W-1:0]   rd_sync;
  wire [`PTR_W-1:0]   wr_vis;
  wire [`PTR_W-1:0]   rd_vis;
  wire [`PTR_W-1:0]   fill_wr;
  wire [`PTR_W-1:0]   fill_rd;
  wire                full_flag;
  wire                present;
  wire                push_ok;
  wire                pop_ok;

  // block-ram style sees writes one clock late
  assign wr_seen = (block_ram_style_param != 0) ? wr_dly_reg : wr_ptr_reg;

  ptr_sync u_wr_sync (
    .mclk_i (mclk_i),
    .rst_i  (rst_i),
    .clr_i  (clr),
    .bin_i  (wr_seen),
    .bin_o  (wr_sync)
  );

  ptr_sync u_rd_sync (
    .mclk_i (mclk_i),
    .rst_i  (rst_i),
    .clr_i  (clr),
    .bin_i  (rd_ptr_reg),
    .bin_o  (rd_sync)
  );

  // each side sees the other's pointer directly or through the crossing
  assign wr_vis = (dual_clock_param != 0) ? wr_sync : wr_seen;
  assign rd_vis = (dual_clock_param != 0) ? rd_sync : rd_ptr_reg;

  assign fill_wr   = wr_ptr_reg - rd_vis;
  assign fill_rd   = wr_vis - rd_ptr_reg;
  assign full_flag = (fill_wr == `DEPTH_PTR) & ~chan_rst_reg;
  assign present   = (fill_rd != {`PTR_W{1'b0}}) & ~chan_rst_reg;

  // overrun and underrun are refused to keep pointers sane
  assign push_ok = push_i & ~full_flag & ~clr;
  assign pop_ok  = pop_i & present & ~clr;

  always @(posedge mclk_i or posedge rst_i) begin
    if (rst_i) begin
      wr_ptr_reg <= {`PTR_W{1'b0}};
      rd_ptr_reg <= {`PTR_W{1'b0}};
      wr_dly_reg <= {`PTR_W{1'b0}};
    end else if (clr) begin
      wr_ptr_reg <= {`PTR_W{1'b0}};
      rd_ptr_reg <= {`PTR_W{1'b0}};
      wr_dly_reg <= {`PTR_W{1'b0}};
    end else begin
      if (push_ok) begin
        wr_ptr_reg <= wr_ptr_reg + 5'h01;
      end
      if (pop_ok) begin
        rd_ptr_reg <= rd_ptr_reg + 5'h01;
      end
      wr_dly_reg <= wr_ptr_reg;
    end
  end

  // ---------------- storage ----------------

  reg  [`DATA_W:0]    mem_reg [0:`DEPTH-1];
  wire                tag_in;
  wire [`DATA_W:0]    head_word;

  assign tag_in = (use_tag_param != 0) ? push_tag_i : 1'b0;

  genvar e;
  generate
    for (e = 0; e < `DEPTH; e = e + 1) begin : entry
      always @(posedge mclk_i or posedge rst_i) begin
        if (rst_i) begin
          mem_reg[e] <= {(`DATA_W+1){1'b0}};
        end else if (push_ok && (wr_ptr_reg[`ADDR_W-1:0] == e)) begin
          mem_reg[e] <= {tag_in, push_data_i};
        end
      end
    end
  endgenerate

  // oldest word falls through to the head
  assign head_word   = mem_reg[rd_ptr_reg[`ADDR_W-1:0]];
  assign head_data_o = head_word[`DATA_W-1:0];
  assign head_tag_o  = (use_tag_param != 0) ? head_word[`DATA_W] : 1'b0;

  // ---------------- flags and level indications ----------------

  // producer is held off during channel reset
  assign full_o         = full_flag | chan_rst_reg;
  assign present_o      = present;
  assign nonempty_irq_o = present;
  assign full_irq_o     = full_flag;
  assign tag_irq_o      = head_tag_o & present;

  // ---------------- event capture ----------------

  reg                 present_q_reg;
  reg                 full_q_reg;
  reg                 tag_q_reg;
  wire [`EV_W-1:0]    ev;

  always @(posedge mclk_i or posedge rst_i) begin
    if (rst_i) begin
      present_q_reg <= 1'b0;
      full_q_reg    <= 1'b0;
      tag_q_reg     <= 1'b0;
    end else begin
      present_q_reg <= present;
      full_q_reg    <= full_flag;
      tag_q_reg     <= tag_irq_o;
    end
  end

  assign ev[`EV_NONEMPTY]  = present & ~present_q_reg;
  assign ev[`EV_FULL]      = full_flag & ~full_q_reg;
  assign ev[`EV_TAG]       = tag_irq_o & ~tag_q_reg;
  assign ev[`EV_OVERFLOW]  = push_i & full_flag & ~clr;
  assign ev[`EV_UNDERFLOW] = pop_i & ~present & ~clr;

  // ---------------- apb slave ----------------

  reg  [`EV_W-1:0]    status_reg;
  reg  [`EV_W-1:0]    status_next;
  reg  [`EV_W-1:0]    mask_reg;
  reg  [31:0]         prdata_reg;
  reg  [31:0]         rd_mux;
  wire                setup;
  wire                access;
  wire                hit;
  wire                wr_ctrl;
  wire                wr_mask;
  wire                rd_status;

  assign setup  = psel_i & ~penable_i;
  assign access = psel_i & penable_i;

  assign hit = (paddr_i == `OFF_CTRL) | (paddr_i == `OFF_STATUS) |
               (paddr_i == `OFF_MASK) | (paddr_i == `OFF_LEVEL);

  assign wr_ctrl   = access & pwrite_i & (paddr_i == `OFF_CTRL);
  assign wr_mask   = access & pwrite_i & (paddr_i == `OFF_MASK);
  assign rd_status = access & ~pwrite_i & (paddr_i == `OFF_STATUS);

  // zero wait states; unmapped addresses answer with an error
  assign pready_o  = 1'b1;
  assign pslverr_o = access & ~hit;
  assign prdata_o  = prdata_reg;

  always @* begin
    rd_mux = 32'h00000000;
    case (paddr_i)
      `OFF_CTRL: begin
        rd_mux[`CTRL_FLUSH] = flush_reg;
      end
      `OFF_STATUS: begin
        rd_mux[`EV_W-1:0] = status_reg;
      end
      `OFF_MASK: begin
        rd_mux[`EV_W-1:0] = mask_reg;
      end
      `OFF_LEVEL: begin
        rd_mux[`LV_PRESENT]                 = present;
        rd_mux[`LV_FULL]                    = full_flag;
        rd_mux[`LV_TAG]                     = tag_irq_o;
        rd_mux[`LV_CHAN_RST]                = chan_rst_reg;
        rd_mux[`LV_CNT_MSB:`LV_CNT_LSB]     = fill_rd;
      end
      default: begin
        rd_mux = 32'h00000000;
      end
    endcase
  end

  // read clears only the bits that were returned; new events win
  always @* begin
    status_next = status_reg;
    if (rd_status) begin
      status_next = status_next & ~prdata_reg[`EV_W-1:0];
    end
    status_next = status_next | ev;
  end

  always @(posedge mclk_i or posedge rst_i) begin
    if (rst_i) begin
      prdata_reg <= 32'h00000000;
      status_reg <= `STATUS_RST;
      mask_reg   <= `MASK_RST;
      flush_reg  <= 1'b0;
    end else begin
      if (setup && !pwrite_i) begin
        prdata_reg <= rd_mux;
      end
      status_reg <= status_next;
      if (wr_mask) begin
        mask_reg <= pwdata_i[`EV_W-1:0];
      end
      // flush is a one-clock pulse
      flush_reg <= wr_ctrl & pwdata_i[`CTRL_FLUSH];
    end
  end

  assign irq_o = |(status_reg & mask_reg);

endmodule // simplex_fifo_channel

// ==== chan_consumer.sv ====
// far-side reader model: pops the head word whenever told to go
// assumes go_i changes just after a rising edge of the shared clock
`timescale 1ns/1ps
module chan_consumer (
  input  wire logic present_i,
  input  wire logic go_i,
  output logic      pop_o
);
  // one acknowledge per word, never on an empty fifo
  assign pop_o = present_i & go_i;
endmodule // chan_consumer

// ==== simplex_fifo_channel_monitor.sv ====
// concurrent checks on the fifo channel ports
// assumes a bind onto simplex_fifo_channel with one clock mclk_i
`timescale 1ns/1ps
module fifo_channel_monitor #(
  parameter int lag_param = 0
) (
  input wire logic mclk_i,
  input wire logic rst_i,
  input wire logic chan_rst_o,
  input wire logic push_i,
  input wire logic full_o,
  input wire logic present_o,
  input wire logic pop_i,
  input wire logic head_tag_o,
  input wire logic nonempty_irq_o,
  input wire logic full_irq_o,
  input wire logic tag_irq_o
);
  logic [4:0] rcnt;
  // edges seen since release while channel reset stays up
  always @(posedge mclk_i or posedge rst_i)
    if (rst_i) rcnt <= 5'h00;
    else if (chan_rst_o && rcnt != 5'h1F) rcnt <= rcnt + 5'h01;
  default clocking @(posedge mclk_i); endclocking
  default disable iff (rst_i);
  rst_len_a: assert property ($fell(chan_rst_o) |-> rcnt == 5'h11) else $error("reset stretch short");
  rst_max_a: assert property (rcnt <= 5'h11) else $error("reset stretch long");
  rst_state_a: assert property (chan_rst_o |-> full_o && !present_o) else $error("flags in reset");
  push_pres_a: assert property (lag_param == 0 && push_i && !full_o |=> present_o) else $error("push not shown");
  push_lag_a: assert property (lag_param != 0 && push_i && !full_o |-> ##[2:5] present_o)
    else $error("late push not shown");
  full_drop_a: assert property (full_o && pop_i && !chan_rst_o |=> !full_o) else $error("full kept");
  push_pop_a: assert property (pop_i && push_i && present_o && !full_o |=> present_o && !full_o) else $error("pp");
  tag_irq_a: assert property (tag_irq_o == (head_tag_o && present_o)) else $error("tag irq wrong");
  irq_follow_a: assert property (nonempty_irq_o == present_o && full_irq_o == (full_o && !chan_rst_o))
    else $error("level irq wrong");
  cover property (full_o && pop_i && !chan_rst_o);
  cover property (pop_i && push_i && present_o);
  cover property (tag_irq_o && pop_i);
endmodule // fifo_channel_monitor

// ==== simplex_fifo_channel_tb_top.sv ====
// testbench: producer, apb master and queue model around the fifo channel
// assumes chan_consumer as reader and the monitor bound at the foot
`timescale 1ns/1ps
module simplex_fifo_channel_tb_top;
  logic        mclk_i = 1'b0;
  logic        rst_i = 1'b1;
  logic        push_i = 1'b0, push_tag_i = 1'b0, go = 1'b0, ovf = 1'b0, err;
  logic        psel_i = 1'b0, penable_i = 1'b0, pwrite_i = 1'b0;
  logic [7:0]  paddr_i = 8'h00;
  logic [1:0]  mode = 2'h0;
  logic [31:0] push_data_i = 32'h0, pwdata_i = 32'h0, rd, rnd;
  wire  [31:0] head_data_o, prdata_o;
  wire         chan_rst_o, full_o, head_tag_o, present_o, pop_i, nonempty_irq_o;
  wire         full_irq_o, tag_irq_o, pready_o, pslverr_o, irq_o;
  logic        push2 = 1'b0, pop2 = 1'b0;
  logic [31:0] data2 = 32'h0, w;
  wire  [31:0] head2;
  wire         tag2, pres2;
  logic [32:0] q[$];
  integer      seed = 17475, miscompares = 0, total_checks = 0, pushed = 0, target = 0, n, s;
  always #20 mclk_i = ~mclk_i;
  simplex_fifo_channel dut (.mclk_i(mclk_i), .rst_i(rst_i), .chan_rst_o(chan_rst_o), .push_i(push_i),
    .push_data_i(push_data_i), .push_tag_i(push_tag_i), .full_o(full_o), .head_data_o(head_data_o),
    .head_tag_o(head_tag_o), .present_o(present_o), .pop_i(pop_i), .nonempty_irq_o(nonempty_irq_o),
    .full_irq_o(full_irq_o), .tag_irq_o(tag_irq_o), .psel_i(psel_i), .penable_i(penable_i),
    .pwrite_i(pwrite_i), .paddr_i(paddr_i), .pwdata_i(pwdata_i), .prdata_o(prdata_o),
    .pready_o(pready_o), .pslverr_o(pslverr_o), .irq_o(irq_o));
  chan_consumer reader (.present_i(present_o), .go_i(go), .pop_o(pop_i));
  // block-ram style over the gray crossing, tag propagation off
  simplex_fifo_channel #(.block_ram_style_param(1), .dual_clock_param(1), .use_tag_param(0)) dut_lag (
    .mclk_i(mclk_i), .rst_i(rst_i), .chan_rst_o(), .push_i(push2), .push_data_i(data2), .push_tag_i(1'b1),
    .full_o(), .head_data_o(head2), .head_tag_o(tag2), .present_o(pres2), .pop_i(pop2), .nonempty_irq_o(),
    .full_irq_o(), .tag_irq_o(), .psel_i(1'b0), .penable_i(1'b0), .pwrite_i(1'b0), .paddr_i(8'h00),
    .pwdata_i(32'h00000000), .prdata_o(), .pready_o(), .pslverr_o(), .irq_o());
  task check(input logic [32:0] got, input logic [32:0] exp);
    total_checks++;
    if (got !== exp) begin
      miscompares++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task final_report;
    if (miscompares == 0 && total_checks > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask
  task apb(input logic wr, input logic [7:0] a, input logic [31:0] wd);
    @(posedge mclk_i);
    psel_i <= 1'b1;
    pwrite_i <= wr;
    paddr_i <= a;
    pwdata_i <= wd;
    @(posedge mclk_i);
    penable_i <= 1'b1;
    do @(posedge mclk_i); while (pready_o !== 1'b1);
    rd = prdata_o;
    err = pslverr_o;
    psel_i <= 1'b0;
    penable_i <= 1'b0;
  endtask
  task wait_level(input integer sz);
    do @(posedge mclk_i); while (q.size() != sz || (sz == 0 && pushed != target));
  endtask
  // queue model, producer and consumer pacing
  always @(posedge mclk_i) begin
    s = q.size();
    if (!rst_i && chan_rst_o === 1'b0) begin
      check(present_o, s != 0);
      check(full_o, s == 16);
      if (s != 0) check({head_tag_o, head_data_o}, q[0]);
      check(nonempty_irq_o, s != 0);
      check(full_irq_o, s == 16);
      check(tag_irq_o, s != 0 && q[0][32]);
      if (pop_i && s != 0) void'(q.pop_front());
      if (push_i && s < 16) begin
        q.push_back({push_tag_i, push_data_i});
        pushed++;
      end
    end
    rnd = $random(seed);
    go <= mode[1] | (mode[0] & rnd[0]);
    push_tag_i <= rnd[1];
    push_data_i <= $random(seed);
    push_i <= ovf | (pushed < target && q.size() < 16);
  end
  initial begin
    repeat (6) @(posedge mclk_i);
    rst_i <= 1'b0;
    n = 0;
    do begin
      @(posedge mclk_i);
      n++;
    end while (chan_rst_o === 1'b1);
    check(n - 1, 17);
    apb(1'b0, 8'h08, 32'h0);
    check(rd, 32'h0);
    apb(1'b0, 8'h40, 32'h0);
    check({err, rd}, 33'h100000000);
    target <= 20;
    wait_level(16);
    apb(1'b0, 8'h0C, 32'h0);
    check(rd, {19'h0, 5'h10, 5'h0, q[0][32], 2'h3});
    @(posedge mclk_i);
    ovf <= 1'b1;
    @(posedge mclk_i);
    ovf <= 1'b0;
    repeat (2) @(posedge mclk_i);
    check(irq_o, 1'b0);
    apb(1'b1, 8'h08, 32'h8);
    @(posedge mclk_i);
    check(irq_o, 1'b1);
    apb(1'b0, 8'h04, 32'h0);
    check(rd & 32'h0B, 32'h0B);
    @(posedge mclk_i);
    check(irq_o, 1'b0);
    mode <= 2'h1;
    wait_level(0);
    target <= 80;
    wait_level(0);
    mode <= 2'h2;
    target <= 120;
    wait_level(0);
    // flush a part-filled fifo; the model empties once pointers clear
    mode <= 2'h0;
    target <= 125;
    wait_level(5);
    apb(1'b1, 8'h00, 32'h00000001);
    @(posedge mclk_i);
    @(negedge mclk_i);
    q.delete();
    @(posedge mclk_i);
    w = $random(seed);
    data2 <= w;
    push2 <= 1'b1;
    @(posedge mclk_i);
    push2 <= 1'b0;
    repeat (4) @(posedge mclk_i);
    check(pres2, 1'b0);
    @(posedge mclk_i);
    check(pres2, 1'b1);
    check({tag2, head2}, {1'b0, w});
    pop2 <= 1'b1;
    @(posedge mclk_i);
    pop2 <= 1'b0;
    @(posedge mclk_i);
    check(pres2, 1'b0);
    final_report;
  end
  initial begin
    #400000;
    miscompares++;
    final_report;
  end
endmodule // simplex_fifo_channel_tb_top
bind simplex_fifo_channel fifo_channel_monitor #(.lag_param(block_ram_style_param + 3 * dual_clock_param))
  mon (.mclk_i(mclk_i), .rst_i(rst_i), .chan_rst_o(chan_rst_o),
  .push_i(push_i), .full_o(full_o), .present_o(present_o), .pop_i(pop_i), .head_tag_o(head_tag_o),
  .nonempty_irq_o(nonempty_irq_o), .full_irq_o(full_irq_o), .tag_irq_o(tag_irq_o));
